// *** hw/trace_arb_pkg.sv ***
`default_nettype none
package trace_arb_pkg;

  localparam int MSG_W       = 64;
  localparam int TCODE_W     = 6;
  localparam int QUEUE_DEPTH = 32;
  localparam int RWA_ADDR_W  = 25;
  localparam int ERR_CODE_W  = 5;
  localparam int LINK_W      = 2;

  // Input message codes, and the code of output error report messages
  localparam logic [5:0] TC_DEV_READ   = 6'h38;
  localparam logic [5:0] TC_DEV_WRITE  = 6'h39;
  localparam logic [5:0] TC_RWA_READ   = 6'h07;
  localparam logic [5:0] TC_RWA_WRITE  = 6'h06;
  localparam logic [5:0] TC_REG_ACCESS = 6'h02;
  localparam logic [5:0] TC_ERROR      = 6'h08;

  // Error report codes
  localparam logic [4:0] ERR_OWN_OVR   = 5'h00;
  localparam logic [4:0] ERR_PROG_OVR  = 5'h01;
  localparam logic [4:0] ERR_DATA_OVR  = 5'h02;
  localparam logic [4:0] ERR_INVALID   = 5'h04;
  localparam logic [4:0] ERR_ALL_OVR   = 5'h07;

  // Show-cycle field values that feed program trace
  localparam logic [2:0] SHOW_ALL_FLOW = 3'h5;
  localparam logic [2:0] SHOW_INDIRECT = 3'h6;

  // First address reachable only through the background debug path
  localparam logic [31:0] DEV_PATH_BASE = 32'h0200_0000;

  localparam logic [MSG_W-1:0] MSG_RESET = '0;

  typedef enum logic [2:0] {
    OUT_INVALID   = 3'b000,
    OUT_HANDSHAKE = 3'b001,
    OUT_WATCH     = 3'b010,
    OUT_RWA       = 3'b011,
    OUT_DEV       = 3'b100,
    OUT_QUEUE     = 3'b101,
    OUT_NONE      = 3'b111
  } out_class_e;

  // Trace source slots
  localparam int SRC_OWN  = 0;
  localparam int SRC_PROG = 1;
  localparam int SRC_DATA = 2;
  localparam int SRC_LOW  = 3;
  localparam int NUM_SRC  = 4;

endpackage : trace_arb_pkg
`default_nettype wire

// *** hw/trace_msg_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module trace_msg_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 32
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_flush,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  input  wire logic [WIDTH-1:0] i_wr_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready,
  output logic [WIDTH-1:0]      o_rd_data
);
  import trace_arb_pkg::*;

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } fifo_s;

  fifo_s            st_reg;
  fifo_s            st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_wr;
  logic             do_rd;

  assign o_wr_ready = (st_reg.count != DEPTH[AW:0]);
  assign o_rd_valid = (st_reg.count != '0);
  assign o_rd_data  = mem[st_reg.rd_ptr];
  assign do_wr      = i_wr_valid && o_wr_ready && !i_flush;
  assign do_rd      = i_rd_ready && o_rd_valid && !i_flush;

  always_comb begin
    st_next = st_reg;
    if (i_flush) begin
      st_next = '0;
    end else begin
      if (do_wr) begin
        st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
      end
      if (do_rd) begin
        st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
      end
      st_next.count = st_reg.count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage in entry order, read out oldest first
  always_ff @(posedge i_ref_clk) begin
    if (do_wr) begin
      mem[st_reg.wr_ptr] <= i_wr_data;
    end
  end

endmodule : trace_msg_fifo
`default_nettype wire

// *** hw/link_msg_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_msg_rx #(
  parameter int MSG_BITS = 64
) (
  input  wire logic                          i_ref_clk,
  input  wire logic                          i_rstn,
  input  wire logic                          i_link_clk,
  input  wire logic [1:0]                    i_link_data,
  input  wire logic                          i_link_frame_n,
  output logic                               o_msg_valid,
  output logic [MSG_BITS-1:0]                o_msg_data,
  output logic [$clog2(MSG_BITS):0]          o_msg_bits
);
  import trace_arb_pkg::*;

  localparam int CW = $clog2(MSG_BITS) + 1;

  typedef struct packed {
    logic [3:0]          sync1;
    logic [3:0]          sync2;
    logic                clk_prev;
    logic                active;
    logic [CW-1:0]       cnt;
    logic [MSG_BITS-1:0] shift;
    logic                msg_valid;
    logic [MSG_BITS-1:0] msg_data;
    logic [CW-1:0]       msg_bits;
  } rx_s;

  rx_s  st_reg;
  rx_s  st_next;
  logic link_rise;

  assign link_rise = st_reg.sync2[3] && !st_reg.clk_prev;

  always_comb begin
    st_next           = st_reg;
    st_next.sync1     = {i_link_clk, i_link_data, i_link_frame_n};
    st_next.sync2     = st_reg.sync1;
    st_next.clk_prev  = st_reg.sync2[3];
    st_next.msg_valid = 1'b0;
    if (link_rise) begin
      if (!st_reg.sync2[0]) begin
        if (st_reg.cnt < CW'(MSG_BITS)) begin
          st_next.shift[st_reg.cnt[CW-2:0] +: 2] = st_reg.sync2[2:1];
          st_next.cnt                          = st_reg.cnt + CW'(2);
        end
        st_next.active = 1'b1;
      end else if (st_reg.active) begin
        // One idle link clock closes the message; the next may start at once
        st_next.msg_valid = 1'b1;
        st_next.msg_data  = st_reg.shift;
        st_next.msg_bits  = st_reg.cnt;
        st_next.active    = 1'b0;
        st_next.cnt       = '0;
        st_next.shift     = '0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_msg_valid = st_reg.msg_valid;
  assign o_msg_data  = st_reg.msg_data;
  assign o_msg_bits  = st_reg.msg_bits;

endmodule : link_msg_rx
`default_nettype wire

// *** hw/trace_message_queue_arbiter.sv ***
// Notes on behaviour
// - Output order: invalid/handshake, watchpoint, access reply, debug reply, queued trace last.
// - Handshake shares top output slot with invalid report; invalid report goes first when both are pending.
// - Queue entry order: overrun error report, promoted data, program, data, low priority, ownership.
// - Entry arbitration never changes the output-side order.
// - Data trace is promoted when program writes would otherwise make it lost.
// - Input messages may follow each other with one idle link clock.
// - Data trace snooped from load/store bus, program trace from peripheral bus.
// - Read/write access requests carry a 25-bit address, lowest 32 Mbytes only.
// - Memory from 0x0200_0000 only via codes 0x38/0x39 to the debug path.
// - Program trace also runs with show-cycle field 0b110.
// - The trace queue holds 32 messages before overflow.
// - Flush mode reports single-kind overrun codes for ownership, program or data; low priority alone or several kinds report 0b00111.
`timescale 1ns/1ps
`default_nettype none
module trace_message_queue_arbiter #(
  parameter int QDEPTH = trace_arb_pkg::QUEUE_DEPTH
) (
  input  wire logic                              i_ref_clk,
  input  wire logic                              i_rstn,
  input  wire logic                              i_link_clk,
  input  wire logic [1:0]                        i_link_data,
  input  wire logic                              i_link_frame_n,
  input  wire logic                              i_prog_valid,
  input  wire logic [trace_arb_pkg::MSG_W-1:0]   i_prog_msg,
  input  wire logic                              i_data_valid,
  input  wire logic [trace_arb_pkg::MSG_W-1:0]   i_data_msg,
  input  wire logic                              i_low_valid,
  input  wire logic [trace_arb_pkg::MSG_W-1:0]   i_low_msg,
  input  wire logic                              i_own_valid,
  input  wire logic [trace_arb_pkg::MSG_W-1:0]   i_own_msg,
  input  wire logic [2:0]                        i_show_cycle_serialise_field,
  input  wire logic                              i_queue_flush_select,
  input  wire logic                              i_hs_valid,
  input  wire logic [trace_arb_pkg::MSG_W-1:0]   i_hs_msg,
  input  wire logic                              i_wp_valid,
  input  wire logic [trace_arb_pkg::MSG_W-1:0]   i_wp_msg,
  input  wire logic                              i_rwa_reply_valid,
  input  wire logic [trace_arb_pkg::MSG_W-1:0]   i_rwa_reply_msg,
  input  wire logic                              i_dev_reply_valid,
  input  wire logic [trace_arb_pkg::MSG_W-1:0]   i_dev_reply_msg,
  input  wire logic                              i_out_ready,
  output logic                                   o_out_valid,
  output logic [2:0]                             o_out_class,
  output logic [trace_arb_pkg::MSG_W-1:0]        o_out_msg,
  output logic                                   o_rwa_req,
  output logic                                   o_rwa_write,
  output logic [trace_arb_pkg::RWA_ADDR_W-1:0]   o_rwa_addr,
  output logic [trace_arb_pkg::MSG_W-1:0]        o_rwa_payload,
  output logic                                   o_dev_req,
  output logic                                   o_dev_write,
  output logic [trace_arb_pkg::MSG_W-1:0]        o_dev_payload,
  output logic                                   o_reg_req,
  output logic [trace_arb_pkg::MSG_W-1:0]        o_reg_payload
);
  import trace_arb_pkg::*;
  localparam int BW = $clog2(MSG_W) + 1;
  typedef struct packed {
    logic [NUM_SRC-1:0]            src_pend;
    logic [NUM_SRC-1:0][MSG_W-1:0] src_msg;
    logic                          data_promote;
    logic [NUM_SRC-1:0]            lost;
    logic                          err_pend;
    logic                          inv_pend;
    logic                          hs_pend;
    logic [MSG_W-1:0]              hs_msg;
    logic                          wp_pend;
    logic [MSG_W-1:0]              wp_msg;
    logic                          rwa_pend;
    logic [MSG_W-1:0]              rwa_msg;
    logic                          dev_pend;
    logic [MSG_W-1:0]              dev_msg;
    logic                          out_valid;
    logic [2:0]                    out_class;
    logic [MSG_W-1:0]              out_msg;
    logic                          rwa_req;
    logic                          rwa_write;
    logic [RWA_ADDR_W-1:0]         rwa_addr;
    logic [MSG_W-1:0]              rwa_payload;
    logic                          dev_req;
    logic                          dev_write;
    logic [MSG_W-1:0]              dev_payload;
    logic                          reg_req;
    logic [MSG_W-1:0]              reg_payload;
  } arb_s;
  arb_s               st_reg;
  arb_s               st_next;
  logic               rx_valid;
  logic [MSG_W-1:0]   rx_data;
  logic [BW-1:0]      rx_bits;
  logic               q_wr_valid;
  logic               q_wr_ready;
  logic [MSG_W-1:0]   q_wr_data;
  logic               q_rd_valid;
  logic               q_rd_ready;
  logic [MSG_W-1:0]   q_rd_data;
  logic               q_flush;
  logic               prog_en;
  logic [NUM_SRC-1:0] src_in;
  logic [NUM_SRC-1:0][MSG_W-1:0] src_in_msg;
  logic [NUM_SRC-1:0] src_grant;
  logic               err_grant;
  logic [NUM_SRC-1:0] lost_now;
  logic [NUM_SRC-1:0] lost_all;
  logic               out_free;
  logic [5:0]         rx_tcode;
  function automatic logic [MSG_W-1:0] error_msg(input logic [4:0] code);
    error_msg = {{(MSG_W-TCODE_W-ERR_CODE_W){1'b0}}, code, TC_ERROR};
  endfunction : error_msg
  function automatic logic [4:0] overrun_code(input logic [NUM_SRC-1:0] kinds, input logic flush_mode);
    overrun_code = ERR_ALL_OVR;
    if (flush_mode) begin
      case (kinds)
        4'b0001: overrun_code = ERR_OWN_OVR;
        4'b0010: overrun_code = ERR_PROG_OVR;
        4'b0100: overrun_code = ERR_DATA_OVR;
        default: overrun_code = ERR_ALL_OVR;
      endcase
    end
  endfunction : overrun_code
  link_msg_rx #(
    .MSG_BITS (MSG_W)
  ) u_link_rx (
    .i_ref_clk      (i_ref_clk),
    .i_rstn         (i_rstn),
    .i_link_clk     (i_link_clk),
    .i_link_data    (i_link_data),
    .i_link_frame_n (i_link_frame_n),
    .o_msg_valid    (rx_valid),
    .o_msg_data     (rx_data),
    .o_msg_bits     (rx_bits)
  );
  trace_msg_fifo #(
    .WIDTH (MSG_W),
    .DEPTH (QDEPTH)
  ) u_queue (
    .i_ref_clk  (i_ref_clk),
    .i_rstn     (i_rstn),
    .i_flush    (q_flush),
    .i_wr_valid (q_wr_valid),
    .o_wr_ready (q_wr_ready),
    .i_wr_data  (q_wr_data),
    .o_rd_valid (q_rd_valid),
    .i_rd_ready (q_rd_ready),
    .o_rd_data  (q_rd_data)
  );
  assign rx_tcode = rx_data[TCODE_W-1:0];
  // Program trace follows either supported show-cycle setting
  assign prog_en = (i_show_cycle_serialise_field == SHOW_ALL_FLOW) ||
                   (i_show_cycle_serialise_field == SHOW_INDIRECT);
  // Data from load/store bus snoop, program from peripheral bus snoop
  assign src_in[SRC_OWN]      = i_own_valid;
  assign src_in[SRC_PROG]     = i_prog_valid && prog_en;
  assign src_in[SRC_DATA]     = i_data_valid;
  assign src_in[SRC_LOW]      = i_low_valid;
  assign src_in_msg[SRC_OWN]  = i_own_msg;
  assign src_in_msg[SRC_PROG] = i_prog_msg;
  assign src_in_msg[SRC_DATA] = i_data_msg;
  assign src_in_msg[SRC_LOW]  = i_low_msg;
  // Queue-entry arbitration, independent of output arbitration
  always_comb begin
    src_grant = '0;
    err_grant = 1'b0;
    q_wr_data = MSG_RESET;
    if (q_wr_ready && !q_flush) begin
      if (st_reg.err_pend) begin
        err_grant = 1'b1;
        q_wr_data = error_msg(overrun_code(st_reg.lost, i_queue_flush_select));
      end else if (st_reg.src_pend[SRC_DATA] && st_reg.data_promote) begin
        src_grant[SRC_DATA] = 1'b1;
      end else if (st_reg.src_pend[SRC_PROG]) begin
        src_grant[SRC_PROG] = 1'b1;
      end else if (st_reg.src_pend[SRC_DATA]) begin
        src_grant[SRC_DATA] = 1'b1;
      end else if (st_reg.src_pend[SRC_LOW]) begin
        src_grant[SRC_LOW] = 1'b1;
      end else if (st_reg.src_pend[SRC_OWN]) begin
        src_grant[SRC_OWN] = 1'b1;
      end
      for (int s = 0; s < NUM_SRC; s++) begin
        if (src_grant[s]) begin
          q_wr_data = st_reg.src_msg[s];
        end
      end
    end
    q_wr_valid = err_grant || (src_grant != '0);
  end
  // A new message meeting a still-held one of its kind is discarded; a flush cycle grants none
  assign lost_now = src_in & st_reg.src_pend & ~src_grant;
  assign lost_all = (err_grant ? '0 : st_reg.lost) | lost_now;
  assign q_flush  = ((src_in & st_reg.src_pend) != '0) && i_queue_flush_select;
  // Output side keeps its fixed order whatever the entry side does
  assign out_free   = !st_reg.out_valid || i_out_ready;
  assign q_rd_ready = out_free && !(st_reg.inv_pend || st_reg.hs_pend || st_reg.wp_pend ||
                                    st_reg.rwa_pend || st_reg.dev_pend);
  always_comb begin
    st_next         = st_reg;
    st_next.rwa_req = 1'b0;
    st_next.dev_req = 1'b0;
    st_next.reg_req = 1'b0;

    for (int s = 0; s < NUM_SRC; s++) begin
      if (src_grant[s]) begin
        st_next.src_pend[s] = 1'b0;
      end
      if (src_in[s] && (!st_reg.src_pend[s] || src_grant[s])) begin
        st_next.src_pend[s] = 1'b1;
        st_next.src_msg[s]  = src_in_msg[s];
      end
    end

    // Promote held data once program trace has taken the queue slot over it
    if (src_grant[SRC_DATA]) begin
      st_next.data_promote = 1'b0;
    end else if (src_grant[SRC_PROG] && st_reg.src_pend[SRC_DATA]) begin
      st_next.data_promote = 1'b1;
    end

    st_next.lost = lost_all;
    if (lost_now != '0) begin
      st_next.err_pend = 1'b1;
    end else if (err_grant) begin
      st_next.err_pend = 1'b0;
    end

    // Decode of tool input messages
    if (rx_valid) begin
      if (rx_bits < BW'(TCODE_W)) begin
        st_next.inv_pend = 1'b1;
      end else begin
        case (rx_tcode)
          TC_DEV_READ, TC_DEV_WRITE: begin
            st_next.dev_req     = 1'b1;
            st_next.dev_write   = (rx_tcode == TC_DEV_WRITE);
            st_next.dev_payload = {{TCODE_W{1'b0}}, rx_data[MSG_W-1:TCODE_W]};
          end
          TC_RWA_READ, TC_RWA_WRITE: begin
            // Address field is only 25 bits wide, so it stays below DEV_PATH_BASE
            st_next.rwa_req     = 1'b1;
            st_next.rwa_write   = (rx_tcode == TC_RWA_WRITE);
            st_next.rwa_addr    = rx_data[TCODE_W +: RWA_ADDR_W];
            st_next.rwa_payload = {{(TCODE_W+RWA_ADDR_W){1'b0}}, rx_data[MSG_W-1:TCODE_W+RWA_ADDR_W]};
          end
          TC_REG_ACCESS: begin
            st_next.reg_req     = 1'b1;
            st_next.reg_payload = {{TCODE_W{1'b0}}, rx_data[MSG_W-1:TCODE_W]};
          end
          default: begin
            st_next.inv_pend = 1'b1;
          end
        endcase
      end
    end

    if (i_hs_valid && !st_reg.hs_pend) begin
      st_next.hs_pend = 1'b1;
      st_next.hs_msg  = i_hs_msg;
    end
    if (i_wp_valid && !st_reg.wp_pend) begin
      st_next.wp_pend = 1'b1;
      st_next.wp_msg  = i_wp_msg;
    end
    if (i_rwa_reply_valid && !st_reg.rwa_pend) begin
      st_next.rwa_pend = 1'b1;
      st_next.rwa_msg  = i_rwa_reply_msg;
    end
    if (i_dev_reply_valid && !st_reg.dev_pend) begin
      st_next.dev_pend = 1'b1;
      st_next.dev_msg  = i_dev_reply_msg;
    end

    // Output arbiter; invalid report wins over handshake when both are pending
    if (out_free) begin
      st_next.out_valid = 1'b1;
      if (st_reg.inv_pend) begin
        st_next.out_class = OUT_INVALID;
        st_next.out_msg   = error_msg(ERR_INVALID);
        st_next.inv_pend  = rx_valid && ((rx_bits < BW'(TCODE_W)) || !(rx_tcode inside
                            {TC_DEV_READ, TC_DEV_WRITE, TC_RWA_READ, TC_RWA_WRITE, TC_REG_ACCESS}));
      end else if (st_reg.hs_pend) begin
        st_next.out_class = OUT_HANDSHAKE;
        st_next.out_msg   = st_reg.hs_msg;
        st_next.hs_pend   = i_hs_valid;
        st_next.hs_msg    = i_hs_msg;
      end else if (st_reg.wp_pend) begin
        st_next.out_class = OUT_WATCH;
        st_next.out_msg   = st_reg.wp_msg;
        st_next.wp_pend   = i_wp_valid;
        st_next.wp_msg    = i_wp_msg;
      end else if (st_reg.rwa_pend) begin
        st_next.out_class = OUT_RWA;
        st_next.out_msg   = st_reg.rwa_msg;
        st_next.rwa_pend  = i_rwa_reply_valid;
        st_next.rwa_msg   = i_rwa_reply_msg;
      end else if (st_reg.dev_pend) begin
        st_next.out_class = OUT_DEV;
        st_next.out_msg   = st_reg.dev_msg;
        st_next.dev_pend  = i_dev_reply_valid;
        st_next.dev_msg   = i_dev_reply_msg;
      end else if (q_rd_valid) begin
        st_next.out_class = OUT_QUEUE;
        st_next.out_msg   = q_rd_data;
      end else begin
        st_next.out_valid = 1'b0;
        st_next.out_class = OUT_NONE;
      end
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      st_reg           <= '0;
      st_reg.out_class <= OUT_NONE;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_out_valid   = st_reg.out_valid;
  assign o_out_class   = st_reg.out_class;
  assign o_out_msg     = st_reg.out_msg;
  assign o_rwa_req     = st_reg.rwa_req;
  assign o_rwa_write   = st_reg.rwa_write;
  assign o_rwa_addr    = st_reg.rwa_addr;
  assign o_rwa_payload = st_reg.rwa_payload;
  assign o_dev_req     = st_reg.dev_req;
  assign o_dev_write   = st_reg.dev_write;
  assign o_dev_payload = st_reg.dev_payload;
  assign o_reg_req     = st_reg.reg_req;
  assign o_reg_payload = st_reg.reg_payload;
endmodule : trace_message_queue_arbiter
`default_nettype wire

// *** verif/trace_arb_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module trace_arb_asserts (
  input wire logic                            i_ref_clk,
  input wire logic                            i_rstn,
  input wire logic                            i_link_frame_n,
  input wire logic                            i_hs_valid,
  input wire logic                            i_out_ready,
  input wire logic                            o_out_valid,
  input wire logic [2:0]                      o_out_class,
  input wire logic [trace_arb_pkg::MSG_W-1:0] o_out_msg,
  input wire logic                            o_rwa_req,
  input wire logic [24:0]                     o_rwa_addr,
  input wire logic                            o_dev_req,
  input wire logic                            o_reg_req
);
  import trace_arb_pkg::*;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  out_hold_a: assert property (o_out_valid && !i_out_ready |=>
    o_out_valid && $stable(o_out_msg) && $stable(o_out_class)) else $error("output changed before accept");
  out_class_a: assert property (o_out_valid |-> o_out_class <= 3'h5) else $error("bad output class");
  hs_top_a: assert property (i_hs_valid && !o_out_valid |->
    ##[1:2] (o_out_valid && o_out_class == 3'h1)) else $error("handshake not sent first");
  rwa_pulse_a: assert property (o_rwa_req |=> !o_rwa_req) else $error("access request too long");
  dev_pulse_a: assert property ($rose(o_dev_req) |=> $fell(o_dev_req)) else $error("debug request too long");
  req_onehot_a: assert property ($onehot0({o_rwa_req, o_dev_req, o_reg_req})) else $error("two requests");
  addr_hold_a: assert property (!o_rwa_req ##1 !o_rwa_req |-> $stable(o_rwa_addr)) else $error("address not held");
  req_idle_a: assert property (o_rwa_req || o_dev_req || o_reg_req |-> $past(i_link_frame_n, 4))
    else $error("request inside a frame");
endmodule : trace_arb_asserts
bind trace_message_queue_arbiter trace_arb_asserts u_trace_arb_asserts (.*);
`default_nettype wire

// *** verif/link_tool_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_tool_model (
  output logic       o_link_clk,
  output logic [1:0] o_link_data,
  output logic       o_link_frame_n
);
  initial begin
    o_link_clk = 1'b0;
    o_link_data = 2'h0;
    o_link_frame_n = 1'b1;
  end
  // Clock runs within a frame plus one idle clock after it; each pair is set while the clock is low
  task automatic send(input logic [63:0] msg, input int pairs);
    for (int i = 0; i < pairs; i++) begin
      o_link_data = msg[2*i +: 2];
      o_link_frame_n = 1'b0;
      #400 o_link_clk = 1'b1;
      #400 o_link_clk = 1'b0;
    end
    o_link_data = ~o_link_data;
    o_link_frame_n = 1'b1;
    #400 o_link_clk = 1'b1; // Single idle clock, next message may follow
    #400 o_link_clk = 1'b0;
  endtask : send
endmodule : link_tool_model
`default_nettype wire

// *** verif/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import trace_arb_pkg::*;
  logic        clk, rstn, lclk, lfr_n, ordy, flush, ovld, rreq, rwr, dreq, dwr, greq;
  logic [1:0]  ldat, dw;
  logic [2:0]  show, ocls;
  logic [7:0]  sv;
  logic [24:0] raddr, ra;
  logic [63:0] sm [8];
  logic [63:0] omsg, rpay, rp, dpay, dp, gpay, gp;
  logic [1:0]  rw;
  int          err_total, samples_checked, dn;
  always #50 clk = ~clk;
  link_tool_model u_link_tool_model (.o_link_clk(lclk), .o_link_data(ldat), .o_link_frame_n(lfr_n));
  trace_message_queue_arbiter u_trace_message_queue_arbiter (
    .i_ref_clk(clk), .i_rstn(rstn), .i_link_clk(lclk), .i_link_data(ldat), .i_link_frame_n(lfr_n),
    .i_prog_valid(sv[0]), .i_prog_msg(sm[0]), .i_data_valid(sv[1]), .i_data_msg(sm[1]),
    .i_low_valid(sv[2]), .i_low_msg(sm[2]), .i_own_valid(sv[3]), .i_own_msg(sm[3]),
    .i_show_cycle_serialise_field(show), .i_queue_flush_select(flush),
    .i_hs_valid(sv[4]), .i_hs_msg(sm[4]), .i_wp_valid(sv[5]), .i_wp_msg(sm[5]),
    .i_rwa_reply_valid(sv[6]), .i_rwa_reply_msg(sm[6]), .i_dev_reply_valid(sv[7]), .i_dev_reply_msg(sm[7]),
    .i_out_ready(ordy), .o_out_valid(ovld), .o_out_class(ocls), .o_out_msg(omsg),
    .o_rwa_req(rreq), .o_rwa_write(rwr), .o_rwa_addr(raddr), .o_rwa_payload(rpay),
    .o_dev_req(dreq), .o_dev_write(dwr), .o_dev_payload(dpay), .o_reg_req(greq), .o_reg_payload(gpay));
  always @(posedge clk) begin
    if (rreq) begin
      ra <= raddr;
      rw <= {rw[0], rwr};
      rp <= rpay;
    end
    if (dreq) begin
      dn <= dn + 1;
      dw <= {dw[0], dwr};
      dp <= dpay;
    end
    if (greq) gp <= gpay;
  end
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Waits for a message, checks it, then lets the accepting edge pass
  task automatic take(input logic [2:0] c, input logic [63:0] m);
    int n;
    n = 0;
    while (ovld !== 1'b1 && n < 80) begin
      @(negedge clk);
      n++;
    end
    cmp({61'h0, ocls}, {61'h0, c});
    cmp(omsg, m);
    @(negedge clk);
  endtask : take
  task automatic pulse(input logic [7:0] v);
    @(negedge clk) sv = v;
    @(negedge clk) sv = 8'h00;
  endtask : pulse
  task automatic prio_test;
    ordy = 1'b0;
    for (int i = 4; i < 8; i++) sm[i] = 64'(i);
    pulse(8'hF0);
    repeat (4) @(negedge clk);
    ordy = 1'b1;
    for (int i = 4; i < 8; i++) take(3'(i - 3), 64'(i));
  endtask : prio_test
  task automatic queue_test;
    ordy = 1'b0;
    show = SHOW_INDIRECT;
    for (int i = 0; i < 4; i++) sm[i] = 64'h10 + 64'(i);
    @(negedge clk) sv = 8'h0F;
    @(negedge clk) begin
      sv = 8'h01;
      sm[0] = 64'h14;
    end
    @(negedge clk) sv = 8'h00;
    repeat (8) @(negedge clk);
    ordy = 1'b1;
    take(3'h5, 64'h10);
    take(3'h5, 64'h11);
    take(3'h5, 64'h14);
    take(3'h5, 64'h12);
    take(3'h5, 64'h13);
  endtask : queue_test
  task automatic ovf_test;
    ordy = 1'b0;
    for (int i = 0; i < 35; i++) begin
      sm[3] = 64'h100 + 64'(i);
      pulse(8'h08);
    end
    repeat (4) @(negedge clk);
    ordy = 1'b1;
    for (int i = 0; i < 33; i++) take(3'h5, 64'h100 + 64'(i));
    take(3'h5, {53'h0, ERR_ALL_OVR, TC_ERROR});
    take(3'h5, 64'h121);
  endtask : ovf_test
  // Own trace clashes with its held slot while flush mode is on
  task automatic flush_test;
    ordy = 1'b0;
    flush = 1'b1;
    show = SHOW_ALL_FLOW;
    sm[0] = 64'h200;
    sm[3] = 64'h203;
    @(negedge clk) sv = 8'h09;
    @(negedge clk) begin
      sv = 8'h08;
      sm[3] = 64'h204;
    end
    @(negedge clk) sv = 8'h00;
    repeat (4) @(negedge clk);
    ordy = 1'b1;
    take(3'h5, {53'h0, ERR_OWN_OVR, TC_ERROR});
    take(3'h5, 64'h200);
    take(3'h5, 64'h203);
    flush = 1'b0;
  endtask : flush_test
  task automatic link_test;
    ordy = 1'b0;
    u_link_tool_model.send({33'h0, 25'h1FFFFFF, TC_RWA_READ}, 16);
    u_link_tool_model.send({24'h0, 9'h1A5, 25'h0123457, TC_RWA_WRITE}, 20);
    u_link_tool_model.send({48'h0, 10'h2A5, TC_DEV_READ}, 8);
    u_link_tool_model.send({48'h0, 10'h15A, TC_DEV_WRITE}, 8);
    u_link_tool_model.send({56'h0, 2'h1, TC_REG_ACCESS}, 4);
    u_link_tool_model.send(64'h1, 1);
    repeat (10) @(negedge clk);
    cmp({37'h0, rw, ra}, {37'h0, 2'b01, 25'h0123457});
    cmp(rp, 64'h1A5);
    cmp({30'h0, dw, dn}, {30'h0, 2'b01, 32'd2});
    cmp(dp, 64'h15A);
    cmp(gp, 64'h1);
    ordy = 1'b1;
    take(3'h0, {53'h0, ERR_INVALID, TC_ERROR});
  endtask : link_test
  task automatic conclude;
    $display("Mismatches %0d of %0d comparisons", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  initial begin
    #2000000;
    err_total++;
    conclude();
  end
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    ordy = 1'b0;
    flush = 1'b0;
    show = SHOW_ALL_FLOW;
    sv = 8'h00;
    dn = 0;
    dw = 2'h0;
    for (int i = 0; i < 8; i++) sm[i] = 64'h0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    prio_test();
    queue_test();
    ovf_test();
    flush_test();
    link_test();
    conclude();
  end
endmodule : testbench
`default_nettype wire
